// file: design/dmb_pkg.sv
/*
  Shared constants, types and helpers for the DDR3 command-side device
  model and its controller.
  Assumes one 100 MHz clock drives both ends and commands are sampled
  on its rising edge.
*/
package dmb_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ROW_PRECHARGE_TIME_PS = 13125;
  localparam int ROW_PRECHARGE_CYC =
    (ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [4:0] TRP_CYC = 5'(ROW_PRECHARGE_CYC);
  localparam logic [2:0] RD_LATENCY = 3'h5;
  localparam logic [2:0] WR_LATENCY = 3'h4;
  // latency counter loads, device and controller views
  localparam logic [2:0] DEV_RD_CNT = RD_LATENCY - 3'h2;
  localparam logic [2:0] DEV_WR_CNT = WR_LATENCY - 3'h2;
  localparam logic [2:0] CTRL_RD_CNT = RD_LATENCY - 3'h1;
  localparam logic [2:0] CTRL_WR_CNT = WR_LATENCY - 3'h3;
  // auto-precharge holds the bank for the burst plus the precharge
  localparam logic [4:0] AP_HOLD_CYC = TRP_CYC + 5'h0d;
  localparam logic [3:0] COLUMN_COMMAND_SPACING = 4'h4;
  localparam logic [3:0] EIGHT_BEAT_LEN = 4'h8;
  localparam logic [4:0] DLL_LOCK_CYC = 5'h10;
  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR3_SEL = 3'h3;
  localparam int MPR_ENABLE_BIT = 2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [1:0] LOC_CAL_PATTERN = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'haa;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // ---------------------------------------------------------------
  // commands as {ras_n, cas_n, we_n} with chip select low
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_ZQ = 3'h6, CMD_NOP = 3'h7
  } dmb_cmd_t;
  typedef enum logic [1:0] {PH_IDLE, PH_ISSUE, PH_LAT, PH_BURST} dmb_phase_t;
  // ---------------------------------------------------------------
  // controller APB map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_WDATA_LO = 8'h04;
  localparam logic [7:0] OFF_WDATA_HI = 8'h08;
  localparam logic [7:0] OFF_RDATA_LO = 8'h0c;
  localparam logic [7:0] OFF_RDATA_HI = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int CF_OP_LSB = 0;
  localparam int CF_BA_LSB = 4;
  localparam int CF_ADDR_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_DLL = 2;
  localparam int ST_MPR = 3;

  function automatic logic dmb_chopped(input logic [1:0] blMode,
                                       input logic a12);
    return (blMode == BL_ON_THE_FLY) ? !a12 : (blMode == BL_FIXED4);
  endfunction
endpackage

// file: design/dmb_link_if.sv
/*
  Command and data link between the controller and the DDR3 device.
  Assumes both ends share core_clk; the shared data wire is resolved
  here from the two output enables.
*/
`timescale 1ns/1ns
interface dmb_link_if;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [2:0] ba;
  logic [14:0] addr;
  logic [7:0] dqCtrl;
  logic dqCtrlOe;
  logic [7:0] dqDev;
  logic dqDevOe;
  logic [7:0] dq;
  logic dllLocked;

  // undriven wire reads as zero rather than floating
  assign dq = dqDevOe ? dqDev : (dqCtrlOe ? dqCtrl : 8'h00);

  modport dev (
    input csN, rasN, casN, weN, ba, addr, dq,
    output dqDev, dqDevOe, dllLocked
  );
  modport ctrl (
    input dq, dllLocked,
    output csN, rasN, casN, weN, ba, addr, dqCtrl, dqCtrlOe
  );
endinterface

// file: design/dmb_device.sv
/*
  DDR3 die command side: mode registers, readout register reads,
  bank activate and precharge, chopped and eight-beat bursts over a
  small flip-flop array.
  Assumes the controller drives the link from core_clk flops and keeps
  its own timing limits; one beat per clock.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - readout bit clear: array reads and writes
// - readout bit set: reads from location
// - readout data is one bit wide
// - pin 0 carries bit, others copy
// - readout read ignores bank, upper column
// - controller sends column bits 1:0 zero
// - eight-beat readout: bit 2 zero, order
// - chopped: bit 2 picks lower/upper nibble
// - bit 12 chops when enabled, fixed too
// - readout uses normal read latency
// - controller refuses readout before loop lock
// - beat 0 is LSB, beat 7 MSB
// - location 00 returns 0,1 alternating
// - activate opens row in addressed bank
// - row open until bank precharged
// - precharge closes one bank or all
// - activate only after precharge time
// - other bank may run during autoprecharge
// - precharged bank idle until activated
// - precharge accepted when idle, restarts timer
// - bit 12 low chops, high eight beats
module dmb_device
  import dmb_pkg::*;
(
  input logic core_clk,
  input logic rst_n,
  dmb_link_if.dev link,
  output logic [7:0] bankOpen,
  output logic mprActive,
  output logic cmdRefused
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0] mr3;
  logic [1:0] mr0Bl;
  logic [4:0] preTimer [8];
  logic [7:0] openRowLsb;
  logic [4:0] lockCnt;
  dmb_phase_t phase;
  logic [2:0] cnt;
  logic [3:0] left;
  logic [2:0] beat;
  logic isRd;
  logic engMpr;
  logic [2:0] engBank;
  logic engRowLsb;
  // array holds two rows of one burst each per bank
  logic [7:0] mem [128];

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  dmb_cmd_t cmd;
  logic cmdOn;
  logic isMpr;
  logic isCol;
  logic actOk;
  logic colOk;
  logic chop;
  logic [7:0] readByte;

  assign cmd = dmb_cmd_t'({link.rasN, link.casN, link.weN});
  assign cmdOn = !link.csN;
  assign isMpr = mr3[MPR_ENABLE_BIT];
  assign isCol = (cmd == CMD_RD) || (cmd == CMD_WR);
  assign actOk = !bankOpen[link.ba] && (preTimer[link.ba] == 5'h00);
  assign colOk = (phase == PH_IDLE) &&
    ((isMpr && cmd == CMD_RD) || bankOpen[link.ba]);
  assign chop = dmb_chopped(mr0Bl, link.addr[BC_BIT]);

  always_comb begin
    readByte = 8'h00;
    if (engMpr) begin
      if (mr3[1:0] == LOC_CAL_PATTERN) begin
        readByte = {8{CAL_PATTERN[beat]}};
      end
    end else begin
      readByte = mem[{engBank, engRowLsb, beat}];
    end
  end

  // ---------------------------------------------------------------
  // mode registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mr3 <= 3'h0;
      mr0Bl <= BL_FIXED8;
    end else if (cmdOn && cmd == CMD_MRS) begin
      if (link.ba == MR3_SEL) begin
        mr3 <= link.addr[2:0];
      end
      if (link.ba == MR0_SEL) begin
        mr0Bl <= link.addr[1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mprActive <= 1'b0;
    end else begin
      mprActive <= isMpr;
    end
  end

  // ---------------------------------------------------------------
  // bank state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bankOpen <= 8'h00;
      openRowLsb <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        preTimer[i] <= 5'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (preTimer[i] != 5'h00) begin
          preTimer[i] <= preTimer[i] - 5'h01;
        end
        if (cmdOn && cmd == CMD_PRE &&
            (link.addr[AP_BIT] || link.ba == 3'(i))) begin
          bankOpen[i] <= 1'b0;
          preTimer[i] <= TRP_CYC;
        end
      end
      if (cmdOn && cmd == CMD_ACT && actOk) begin
        bankOpen[link.ba] <= 1'b1;
        openRowLsb[link.ba] <= link.addr[0];
      end
      if (cmdOn && isCol && colOk && link.addr[AP_BIT] &&
          !(isMpr && cmd == CMD_RD)) begin
        bankOpen[link.ba] <= 1'b0;
        preTimer[link.ba] <= AP_HOLD_CYC;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmdRefused <= 1'b0;
    end else begin
      cmdRefused <= cmdOn &&
        ((cmd == CMD_ACT && !actOk) || (isCol && !colOk));
    end
  end

  // ---------------------------------------------------------------
  // loop lock after reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lockCnt <= 5'h00;
      link.dllLocked <= 1'b0;
    end else begin
      if (lockCnt != DLL_LOCK_CYC) begin
        lockCnt <= lockCnt + 5'h01;
      end
      link.dllLocked <= (lockCnt == DLL_LOCK_CYC);
    end
  end

  // ---------------------------------------------------------------
  // burst engine
  // ---------------------------------------------------------------
  // overlapping bursts are refused; the spacing guard lives upstream
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
      cnt <= 3'h0;
      left <= 4'h0;
      beat <= 3'h0;
      isRd <= 1'b0;
      engMpr <= 1'b0;
      engBank <= 3'h0;
      engRowLsb <= 1'b0;
    end else begin
      unique case (phase)
        PH_IDLE: begin
          if (cmdOn && isCol && colOk) begin
            phase <= PH_LAT;
            cnt <= (cmd == CMD_RD) ? DEV_RD_CNT : DEV_WR_CNT;
            left <= chop ? COLUMN_COMMAND_SPACING : EIGHT_BEAT_LEN;
            beat <= chop ? {link.addr[2], 2'b00} : 3'h0;
            isRd <= (cmd == CMD_RD);
            engMpr <= isMpr;
            engBank <= link.ba;
            engRowLsb <= openRowLsb[link.ba];
          end
        end
        PH_LAT: begin
          if (cnt == 3'h0) begin
            phase <= PH_BURST;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        PH_BURST: begin
          beat <= beat + 3'h1;
          left <= left - 4'h1;
          if (left == 4'h1) begin
            phase <= PH_IDLE;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link.dqDev <= 8'h00;
      link.dqDevOe <= 1'b0;
    end else begin
      link.dqDevOe <= (phase == PH_BURST) && isRd;
      link.dqDev <= ((phase == PH_BURST) && isRd) ? readByte : 8'h00;
    end
  end

  // writes in readout mode are dropped, the array stays untouched
  always_ff @(posedge core_clk) begin
    if (phase == PH_BURST && !isRd && !engMpr) begin
      mem[{engBank, engRowLsb, beat}] <= link.dq;
    end
  end
endmodule

// file: design/dmb_controller.sv
/*
  DDR3 controller end: an APB slave whose command register issues one
  link command at a time and gathers or sends its burst.
  Assumes the device shares core_clk and answers with the latencies
  held in the package.
*/
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module dmb_controller
  import dmb_pkg::*;
(
  input logic core_clk,
  input logic rst_n,
  dmb_link_if.ctrl link,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [63:0] wdata;
  logic [63:0] rdata;
  logic errFlag;
  logic [2:0] mr3Shadow;
  logic [1:0] mr0Shadow;
  logic [7:0] open;
  logic [4:0] timer [8];
  dmb_phase_t phase;
  logic [2:0] cnt;
  logic [3:0] left;
  logic [2:0] idx;
  logic isRd;
  logic isCol;

  // ---------------------------------------------------------------
  // APB decode and command check
  // ---------------------------------------------------------------
  logic access;
  logic wrCmd;
  dmb_cmd_t op;
  logic [2:0] ba;
  logic [14:0] a;
  logic opOk;
  logic accept;
  logic chop;
  logic [31:0] rmux;
  logic mapped;

  assign access = psel && penable && pready;
  assign wrCmd = access && pwrite && paddr == OFF_CMD;
  assign op = dmb_cmd_t'(pwdata[CF_OP_LSB +: 3]);
  assign ba = pwdata[CF_BA_LSB +: 3];
  assign a = pwdata[CF_ADDR_LSB +: 15];
  assign chop = dmb_chopped(mr0Shadow, a[BC_BIT]);
  assign accept = wrCmd && opOk && phase == PH_IDLE;

  always_comb begin
    opOk = 1'b0;
    unique case (op)
      CMD_NOP, CMD_PRE: opOk = 1'b1;
      CMD_MRS: opOk = !(ba == MR3_SEL && a[MPR_ENABLE_BIT] &&
                        a[1:0] != LOC_CAL_PATTERN);
      CMD_ACT: opOk = !open[ba] && timer[ba] == 5'h00;
      CMD_RD: opOk = mr3Shadow[MPR_ENABLE_BIT] ? link.dllLocked : open[ba];
      CMD_WR: opOk = open[ba];
      CMD_REF, CMD_ZQ: opOk = 1'b0;
    endcase
  end

  always_comb begin
    rmux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      OFF_CMD: rmux = 32'h0000_0000;
      OFF_WDATA_LO: rmux = wdata[31:0];
      OFF_WDATA_HI: rmux = wdata[63:32];
      OFF_RDATA_LO: rmux = rdata[31:0];
      OFF_RDATA_HI: rmux = rdata[63:32];
      OFF_STATUS: begin
        rmux[ST_BUSY] = phase != PH_IDLE;
        rmux[ST_ERR] = errFlag;
        rmux[ST_DLL] = link.dllLocked;
        rmux[ST_MPR] = mr3Shadow[MPR_ENABLE_BIT];
      end
      default: mapped = 1'b0;
    endcase
  end

  // zero-wait answer: pready rises in the access phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable) ? rmux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdata <= 64'h0;
    end else if (access && pwrite && paddr == OFF_WDATA_LO) begin
      wdata[31:0] <= pwdata;
    end else if (access && pwrite && paddr == OFF_WDATA_HI) begin
      wdata[63:32] <= pwdata;
    end
  end

  // a refusal in the clearing cycle still leaves the flag set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      errFlag <= 1'b0;
    end else if (wrCmd && !accept) begin
      errFlag <= 1'b1;
    end else if (access && pwrite && paddr == OFF_STATUS &&
                 pwdata[ST_ERR]) begin
      errFlag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // shadow of device mode and bank state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mr3Shadow <= 3'h0;
      mr0Shadow <= BL_FIXED8;
      open <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        timer[i] <= 5'h00;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (timer[i] != 5'h00) begin
          timer[i] <= timer[i] - 5'h01;
        end
        if (accept && op == CMD_PRE && (a[AP_BIT] || ba == 3'(i))) begin
          open[i] <= 1'b0;
          timer[i] <= TRP_CYC;
        end
      end
      if (accept && op == CMD_MRS && ba == MR3_SEL) begin
        mr3Shadow <= a[2:0];
      end
      if (accept && op == CMD_MRS && ba == MR0_SEL) begin
        mr0Shadow <= a[1:0];
      end
      if (accept && op == CMD_ACT) begin
        open[ba] <= 1'b1;
      end
      if (accept && (op == CMD_WR || (op == CMD_RD &&
          !mr3Shadow[MPR_ENABLE_BIT])) && a[AP_BIT]) begin
        open[ba] <= 1'b0;
        timer[ba] <= AP_HOLD_CYC;
      end
    end
  end

  // ---------------------------------------------------------------
  // link sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
      cnt <= 3'h0;
      left <= 4'h0;
      idx <= 3'h0;
      isRd <= 1'b0;
      isCol <= 1'b0;
      rdata <= 64'h0;
      link.csN <= 1'b1;
      {link.rasN, link.casN, link.weN} <= CMD_NOP;
      link.ba <= 3'h0;
      link.addr <= 15'h0000;
      link.dqCtrl <= 8'h00;
      link.dqCtrlOe <= 1'b0;
    end else begin
      link.dqCtrlOe <= 1'b0;
      link.dqCtrl <= 8'h00;
      unique case (phase)
        PH_IDLE: begin
          if (accept) begin
            phase <= PH_ISSUE;
            link.csN <= 1'b0;
            {link.rasN, link.casN, link.weN} <= op;
            link.ba <= ba;
            link.addr <= a;
            isRd <= op == CMD_RD;
            isCol <= op == CMD_RD || op == CMD_WR;
            cnt <= (op == CMD_RD) ? CTRL_RD_CNT : CTRL_WR_CNT;
            left <= chop ? COLUMN_COMMAND_SPACING : EIGHT_BEAT_LEN;
            idx <= 3'h0;
            if (op == CMD_RD || op == CMD_WR) begin
              link.addr[1:0] <= 2'b00;
              link.addr[2] <= chop & a[2];
            end
            if (op == CMD_RD) begin
              rdata <= 64'h0;
            end
          end
        end
        PH_ISSUE: begin
          link.csN <= 1'b1;
          {link.rasN, link.casN, link.weN} <= CMD_NOP;
          phase <= isCol ? PH_LAT : PH_IDLE;
        end
        PH_LAT: begin
          if (cnt == 3'h0) begin
            phase <= PH_BURST;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        PH_BURST: begin
          if (isRd) begin
            rdata[{idx, 3'h0} +: 8] <= link.dq;
          end else begin
            link.dqCtrl <= wdata[{idx, 3'h0} +: 8];
            link.dqCtrlOe <= 1'b1;
          end
          idx <= idx + 3'h1;
          left <= left - 4'h1;
          if (left == 4'h1) begin
            phase <= PH_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// file: tb/dmb_checker.sv
/*
  Checker for the shared link: command pulses, burst lengths and
  readout patterns, and bank use by the controller.
  Assumes both ends share core_clk; signals come from the interface.
*/
`timescale 1ns/1ns
module dmb_checker
  import dmb_pkg::*;
(
  input logic core_clk,
  input logic rst_n,
  input logic csN,
  input logic rasN,
  input logic casN,
  input logic weN,
  input logic [2:0] ba,
  input logic [14:0] addr,
  input logic [7:0] dqDev,
  input logic dqDevOe,
  input logic dqCtrlOe,
  input logic [7:0] dq,
  input logic dllLocked
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // mode and bank tracking
  // ---------------------------------------------------------------
  logic [2:0] op;
  logic isRd;
  logic isWr;
  logic isAct;
  logic isPre;
  logic chop;
  logic mprMode;
  logic [1:0] blMode;
  logic [7:0] openBank;
  assign op = {rasN, casN, weN};
  assign isRd = !csN && op == CMD_RD;
  assign isWr = !csN && op == CMD_WR;
  assign isAct = !csN && op == CMD_ACT;
  assign isPre = !csN && op == CMD_PRE;
  assign chop = (blMode == BL_ON_THE_FLY) ? !addr[BC_BIT] :
                (blMode == BL_FIXED4);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mprMode <= 1'b0;
      blMode <= BL_FIXED8;
    end else if (!csN && op == CMD_MRS) begin
      if (ba == MR3_SEL)
        mprMode <= addr[MPR_ENABLE_BIT];
      if (ba == MR0_SEL)
        blMode <= addr[1:0];
    end
  end
  // auto-precharge frees the bank at the command, not after the burst
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      openBank <= 8'h00;
    else if (isAct)
      openBank[ba] <= 1'b1;
    else if (isPre && addr[AP_BIT])
      openBank <= 8'h00;
    else if (isPre || ((isWr || (isRd && !mprMode)) && addr[AP_BIT]))
      openBank[ba] <= 1'b0;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_pair;
    (dqDevOe && dq == 8'h00) ##1 (dqDevOe && dq == 8'hff);
  endsequence
  sequence s_off;
    !dqDevOe;
  endsequence
  AST_CS_PULSE:
    assert property ($fell(csN) |=> csN)
    else $error("chip select held low past one cycle");
  AST_RD_LONG:
    assert property (isRd && !chop |-> ##6 dqDevOe [*8] ##1 s_off)
    else $error("eight-beat read burst wrong length or latency");
  AST_RD_SHORT:
    assert property (isRd && chop |-> ##6 dqDevOe [*4] ##1 s_off)
    else $error("chopped read burst wrong length or latency");
  AST_PAT_LONG:
    assert property (isRd && mprMode && !chop |->
      ##6 s_pair ##1 s_pair ##1 s_pair ##1 s_pair ##1 s_off)
    else $error("eight-beat calibration pattern wrong");
  AST_PAT_SHORT:
    assert property (isRd && mprMode && chop |->
      ##6 s_pair ##1 s_pair ##1 s_off)
    else $error("chopped calibration pattern wrong");
  AST_PINS:
    assert property (mprMode && dqDevOe |->
      dqDev == 8'h00 || dqDev == 8'hff)
    else $error("readout pins do not copy pin zero");
  AST_MPR_LOCK:
    assert property (isRd && mprMode |-> dllLocked)
    else $error("readout read before loop lock");
  AST_MPR_COL:
    assert property (isRd && mprMode |->
      addr[1:0] == 2'h0 && (chop || !addr[2]))
    else $error("readout read column bits not zero");
  AST_ACT_CLOSED:
    assert property (isAct |-> !openBank[ba])
    else $error("activate sent to a bank with an open row");
  AST_RDWR_OPEN:
    assert property (isWr || (isRd && !mprMode) |-> openBank[ba])
    else $error("column command sent to an idle bank");
  AST_WR_LONG:
    assert property (isWr && !chop |-> ##4 dqCtrlOe [*8] ##1 !dqCtrlOe)
    else $error("eight-beat write drive wrong length or latency");
endmodule

// file: tb/tb.sv
/*
  Testbench: APB master driving the controller, which faces the device
  over the link interface; the checker watches the link.
  Assumes the controller answers each transfer with pready.
*/
`timescale 1ns/1ns
module tb
  import dmb_pkg::*;
;
  typedef struct packed {
    logic [1:0] bl;
    logic [14:0] ad;
    logic [2:0] bk;
    logic [31:0] lo;
    logic [31:0] hi;
  } dmb_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic lastErr;
  logic [7:0] bankOpen;
  logic mprActive;
  logic [31:0] s;
  int err_total = 0;
  int compares = 0;
  dmb_row_t rows [6];
  dmb_link_if u_dmb_link_if ();
  dmb_device u_dmb_device (.core_clk(core_clk), .rst_n(rst_n),
    .link(u_dmb_link_if), .bankOpen(bankOpen), .mprActive(mprActive),
    .cmdRefused());
  dmb_controller u_dmb_controller (.core_clk(core_clk), .rst_n(rst_n),
    .link(u_dmb_link_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  dmb_checker u_dmb_checker (.core_clk(core_clk), .rst_n(rst_n),
    .csN(u_dmb_link_if.csN), .rasN(u_dmb_link_if.rasN),
    .casN(u_dmb_link_if.casN), .weN(u_dmb_link_if.weN),
    .ba(u_dmb_link_if.ba), .addr(u_dmb_link_if.addr),
    .dqDev(u_dmb_link_if.dqDev), .dqDevOe(u_dmb_link_if.dqDevOe),
    .dqCtrlOe(u_dmb_link_if.dqCtrlOe), .dq(u_dmb_link_if.dq),
    .dllLocked(u_dmb_link_if.dllLocked));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic issue(input logic [2:0] op, input logic [2:0] b,
                       input logic [14:0] a);
    logic [31:0] st;
    apb(1'b1, OFF_CMD, {9'h0, a, 1'b0, b, 1'b0, op}, st);
    st = 32'h1;
    for (int i = 0; i < 40 && st[ST_BUSY] !== 1'b0; i++)
      apb(1'b0, OFF_STATUS, 32'h0, st);
  endtask
  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_flag(input string n, input logic e, input logic g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask
  // reads status, compares the error flag, then clears it
  task automatic chk_err(input string n, input logic e);
    logic [31:0] st;
    apb(1'b0, OFF_STATUS, 32'h0, st);
    chk_flag(n, e, st[ST_ERR]);
    apb(1'b1, OFF_STATUS, 32'h2, st);
  endtask
  task automatic chk_rd(input string n, input logic [31:0] lo,
                        input logic [31:0] hi);
    logic [31:0] d;
    apb(1'b0, OFF_RDATA_LO, 32'h0, d);
    chk_word(n, lo, d);
    apb(1'b0, OFF_RDATA_HI, 32'h0, d);
    chk_word(n, hi, d);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // ignored bits set in several rows: bank, 9:3, 10, 11, 13
    rows[0] = '{2'h0, 15'h0000, 3'h0, 32'hff00ff00, 32'hff00ff00};
    rows[1] = '{2'h1, 15'h1000, 3'h7, 32'hff00ff00, 32'hff00ff00};
    rows[2] = '{2'h1, 15'h0000, 3'h0, 32'hff00ff00, 32'h0};
    rows[3] = '{2'h1, 15'h2ffc, 3'h5, 32'hff00ff00, 32'h0};
    rows[4] = '{2'h2, 15'h1004, 3'h1, 32'hff00ff00, 32'h0};
    rows[5] = '{2'h0, 15'h3ff8, 3'h3, 32'hff00ff00, 32'hff00ff00};
    do_reset();
    issue(CMD_MRS, MR3_SEL, 15'h0004);
    issue(CMD_RD, 3'h0, 15'h0000);
    chk_err("early readout refused", 1'b1);
    s = 32'h0;
    for (int i = 0; i < 40 && s[ST_DLL] !== 1'b1; i++)
      apb(1'b0, OFF_STATUS, 32'h0, s);
    chk_flag("mprActive", 1'b1, mprActive);
    for (int i = 0; i < 6; i++) begin
      issue(CMD_MRS, MR0_SEL, {13'h0, rows[i].bl});
      issue(CMD_RD, rows[i].bk, rows[i].ad);
      chk_rd("readout data", rows[i].lo, rows[i].hi);
      chk_err("readout accepted", 1'b0);
    end
    issue(CMD_MRS, MR3_SEL, 15'h0005);
    chk_err("reserved location", 1'b1);
    issue(CMD_MRS, MR3_SEL, 15'h0000);
    chk_flag("mprActive", 1'b0, mprActive);
    issue(CMD_MRS, MR0_SEL, 15'h0001);
    issue(CMD_ACT, 3'h2, 15'h0001);
    chk_word("bankOpen", 32'h04, {24'h0, bankOpen});
    apb(1'b1, OFF_WDATA_LO, 32'h33221100, s);
    apb(1'b1, OFF_WDATA_HI, 32'h77665544, s);
    issue(CMD_WR, 3'h2, 15'h1000);
    issue(CMD_RD, 3'h2, 15'h1000);
    chk_rd("array eight", 32'h33221100, 32'h77665544);
    issue(CMD_RD, 3'h2, 15'h0004);
    chk_rd("array chopped upper", 32'h77665544, 32'h0);
    chk_err("array accepted", 1'b0);
    issue(CMD_ACT, 3'h2, 15'h0000);
    chk_err("act to open bank", 1'b1);
    issue(CMD_ACT, 3'h5, 15'h0000);
    issue(CMD_PRE, 3'h2, 15'h0000);
    chk_word("bankOpen", 32'h20, {24'h0, bankOpen});
    issue(CMD_RD, 3'h2, 15'h1000);
    chk_err("read idle bank", 1'b1);
    issue(CMD_PRE, 3'h2, 15'h0000);
    chk_err("precharge idle bank", 1'b0);
    issue(CMD_ACT, 3'h2, 15'h0001);
    chk_err("act after precharge", 1'b0);
    issue(CMD_RD, 3'h2, 15'h1400);
    chk_word("bankOpen", 32'h20, {24'h0, bankOpen});
    issue(CMD_RD, 3'h5, 15'h1000);
    chk_err("read other bank", 1'b0);
    issue(CMD_PRE, 3'h0, 15'h0400);
    chk_word("bankOpen", 32'h00, {24'h0, bankOpen});
    apb(1'b0, 8'h18, 32'h0, s);
    chk_flag("pslverr", 1'b1, lastErr);
    chk_word("unmapped read", 32'h0, s);
    do_reset();
    apb(1'b0, OFF_STATUS, 32'h0, s);
    chk_word("status after reset", 32'h0, s);
    chk_rd("rdata after reset", 32'h0, 32'h0);
    chk_flag("mprActive", 1'b0, mprActive);
    give_verdict();
  end
endmodule
